// [design/bfsr_regs.svh]
// timing counts, widths and reset values of the synchronous burst read port
// assumes a 100 MHz core clock that is also the burst clock
`ifndef BFSR_REGS_SVH
`define BFSR_REGS_SVH

`define BFSR_BUS_W 16
`define BFSR_SYNC_W 19
`define BFSR_SYNC_RST 19'h70000
`define BFSR_WORD_RST 16'h0000
`define BFSR_LEN_W 6
`define BFSR_LEN8 6'h08
`define BFSR_LEN16 6'h10
`define BFSR_LEN32 6'h20
`define BFSR_LEN_CONT 6'h00
`define BFSR_WAIT_W 4
`define BFSR_WAIT_MIN 4'h2
`define BFSR_CLK_PERIOD_NS 10
`define BFSR_T_RH_NS 200
`define BFSR_RH_CYCLES ((`BFSR_T_RH_NS + `BFSR_CLK_PERIOD_NS - 1) / `BFSR_CLK_PERIOD_NS)

`endif

// [design/bfsr_pkg.sv]
// types shared by the burst read port and its testbench
// assumes bfsr_regs.svh is on the include path
`include "bfsr_regs.svh"

package bfsr_pkg;

  typedef enum logic [1:0] {
    BM_LIN8,
    BM_LIN16,
    BM_LIN32,
    BM_CONT
  } bfsr_burst_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DATA
  } bfsr_state_t;

endpackage

// [design/bfsr_mem.sv]
// word array behind the burst read port, one write and one registered read port
// assumes the user side loads contents; no reset of the array itself
`timescale 1ns/1ps

module bfsr_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_ff;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (rd_en) begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;

endmodule

// [design/bfsr_port.sv]
// synchronous burst read port of a multiplexed address/data flash
// assumes the bus clock is clk; pins arrive unsynchronised, config is on clk
`timescale 1ns/1ps
`include "bfsr_regs.svh"

module bfsr_port import bfsr_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic address_valid_n,
  input wire logic oe_n,
  input wire logic [`BFSR_BUS_W-1:0] bus_in,
  output logic [`BFSR_BUS_W-1:0] bus_out,
  output logic bus_oe,
  output logic rdy_out,
  output logic rdy_oe,
  input wire logic [`BFSR_WAIT_W-1:0] wait_state_count,
  input wire bfsr_burst_t burst_mode,
  input wire logic wrap_en,
  input wire logic mem_wr_en,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic [`BFSR_BUS_W-1:0] mem_wr_data
);

  // ==========================================================
  // helpers
  function automatic logic [`BFSR_LEN_W-1:0] bfsr_len(input bfsr_burst_t m);
    case (m)
      BM_LIN8: bfsr_len = `BFSR_LEN8;
      BM_LIN16: bfsr_len = `BFSR_LEN16;
      BM_LIN32: bfsr_len = `BFSR_LEN32;
      default: bfsr_len = `BFSR_LEN_CONT;
    endcase
  endfunction

  // wrap keeps the upper bits and cycles the offset inside the aligned group
  function automatic logic [`BFSR_BUS_W-1:0] bfsr_next_addr(
    input logic [`BFSR_BUS_W-1:0] a, input bfsr_burst_t m, input logic wrap);
    logic [`BFSR_BUS_W-1:0] mask;
    logic [`BFSR_BUS_W-1:0] inc;
    mask = {10'h000, bfsr_len(m) - 6'h01};
    inc = a + 16'h0001;
    if (wrap && m != BM_CONT) begin
      bfsr_next_addr = (a & ~mask) | (inc & mask);
    end else begin
      bfsr_next_addr = inc;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [`BFSR_SYNC_W-1:0] sync1_ff;
  logic [`BFSR_SYNC_W-1:0] sync2_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= `BFSR_SYNC_RST;
      sync2_ff <= `BFSR_SYNC_RST;
    end else begin
      sync1_ff <= {ce_n, address_valid_n, oe_n, bus_in};
      sync2_ff <= sync1_ff;
    end
  end

  wire ce_s = sync2_ff[18];
  wire addr_valid_n_s = sync2_ff[17];
  wire oe_s = sync2_ff[16];
  wire [`BFSR_BUS_W-1:0] bus_s = sync2_ff[15:0];

  // ==========================================================
  // burst control
  bfsr_state_t state_ff;
  logic [`BFSR_BUS_W-1:0] base_ff;
  logic [`BFSR_BUS_W-1:0] fetch_addr_ff;
  logic [`BFSR_LEN_W-1:0] fetch_left_ff;
  logic [`BFSR_LEN_W-1:0] out_left_ff;
  logic [`BFSR_WAIT_W-1:0] lat_ff;
  logic inflight_ff;
  logic [`BFSR_BUS_W-1:0] fifo_ff [0:1];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic [`BFSR_BUS_W-1:0] dq_ff;
  logic rdy_ff;
  logic [`BFSR_BUS_W-1:0] mem_rd_data;

  wire start = !ce_s && !addr_valid_n_s;
  wire active = state_ff != ST_IDLE;
  wire is_cont = burst_mode == BM_CONT;
  wire [`BFSR_LEN_W-1:0] len = bfsr_len(burst_mode);
  wire room = ({1'b0, cnt_ff} + {2'h0, inflight_ff}) < 3'h2;
  wire issue = !ce_s && (start || (active && (is_cont || fetch_left_ff != 6'h00) && room));
  wire [`BFSR_BUS_W-1:0] rd_addr = start ? bus_s : fetch_addr_ff;
  wire fifo_has = cnt_ff != 2'h0;
  // the array word bypasses an empty buffer so the shortest latency is met
  wire avail = fifo_has || inflight_ff;
  wire [`BFSR_BUS_W-1:0] head = fifo_has ? fifo_ff[rd_ptr_ff] : mem_rd_data;
  wire pop = active && !start && !ce_s && avail && (lat_ff <= 4'h1) &&
             (is_cont || out_left_ff != 6'h00);
  wire push = inflight_ff && !start && !ce_s && !(pop && !fifo_has);
  wire last = !is_cont && out_left_ff == 6'h01;
  wire [`BFSR_WAIT_W-1:0] lat_init =
    (wait_state_count < `BFSR_WAIT_MIN) ? 4'h1 : wait_state_count - 4'h1;

  bfsr_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start) nxt_state = ST_WAIT;
      ST_WAIT, ST_DATA: begin
        if (start) begin
          nxt_state = ST_WAIT;
        end else if (pop) begin
          nxt_state = last ? ST_IDLE : ST_DATA;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (ce_s) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      base_ff <= `BFSR_WORD_RST;
      fetch_addr_ff <= `BFSR_WORD_RST;
      fetch_left_ff <= 6'h00;
      out_left_ff <= 6'h00;
      lat_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        base_ff <= bus_s;
        fetch_addr_ff <= bfsr_next_addr(bus_s, burst_mode, wrap_en);
        fetch_left_ff <= len - 6'h01;
        out_left_ff <= len;
        lat_ff <= lat_init;
      end else begin
        if (issue) begin
          fetch_addr_ff <= bfsr_next_addr(fetch_addr_ff, burst_mode, wrap_en);
          if (fetch_left_ff != 6'h00) fetch_left_ff <= fetch_left_ff - 6'h01;
        end
        if (pop && out_left_ff != 6'h00) out_left_ff <= out_left_ff - 6'h01;
        if (lat_ff != 4'h0) lat_ff <= lat_ff - 4'h1;
      end
    end
  end

  // ==========================================================
  // two-entry buffer between the array and the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inflight_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      inflight_ff <= issue;
      if (start || ce_s) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
        cnt_ff <= 2'h0;
      end else begin
        if (push) wr_ptr_ff <= !wr_ptr_ff;
        if (pop && fifo_has) rd_ptr_ff <= !rd_ptr_ff;
        cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop && fifo_has};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) fifo_ff[wr_ptr_ff] <= mem_rd_data;
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_ff <= `BFSR_WORD_RST;
      rdy_ff <= 1'b0;
    end else begin
      if (pop) dq_ff <= head;
      rdy_ff <= pop;
    end
  end

  assign bus_out = dq_ff;
  assign bus_oe = !oe_s && !ce_s;
  assign rdy_out = rdy_ff;
  assign rdy_oe = !ce_s;

  bfsr_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(`BFSR_BUS_W)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_en(issue),
    .rd_addr(rd_addr[ADDR_W-1:0]),
    .rd_data(mem_rd_data)
  );

  // ==========================================================
  // checks
  logic [3:0] since_ff;
  logic first_pend_ff;
  // address of the word that the next pop should present, kept apart from the fetch side
  logic [`BFSR_BUS_W-1:0] out_addr_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ff <= 4'h0;
      first_pend_ff <= 1'b0;
      out_addr_ff <= `BFSR_WORD_RST;
    end else begin
      if (start) since_ff <= 4'h0;
      else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
      if (start) first_pend_ff <= 1'b1;
      else if (pop) first_pend_ff <= 1'b0;
      if (start) out_addr_ff <= bus_s;
      else if (pop) out_addr_ff <= bfsr_next_addr(out_addr_ff, burst_mode, wrap_en);
    end
  end

  wire [`BFSR_BUS_W-1:0] grp_mask = {10'h000, len - 6'h01};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_issue_step;
    issue && !start && !ce_s;
  endsequence

  sequence s_pop_step;
    pop;
  endsequence

  AST_ADDR_LATCH: assert property (start |=> base_ff == $past(bus_s))
    else $error("address not latched while address-valid low");
  // judged from the pins themselves, two edges back, so a broken synchroniser shows up
  AST_RDY_FLOAT: assert property ($past(ce_n, 2) |-> !rdy_oe && !bus_oe)
    else $error("ready driven while chip enable high");
  AST_BUS_FLOAT: assert property ($past(oe_n, 2) |-> !bus_oe)
    else $error("bus driven while output enable high");
  AST_WORD_ORDER: assert property (
    s_pop_step |=> dq_ff == u_mem.mem_ff[$past(out_addr_ff[ADDR_W-1:0])])
    else $error("burst word out of address order");
  AST_FIRST_LAT: assert property (
    (pop && first_pend_ff && wait_state_count >= `BFSR_WAIT_MIN) |->
    ({1'b0, since_ff} + 5'h02) == {1'b0, wait_state_count})
    else $error("initial latency differs from wait states minus one");
  AST_RDY_WITH_DATA: assert property (
    s_pop_step |=> rdy_ff && dq_ff == $past(head))
    else $error("ready not aligned with data word");
  AST_NO_RDY_IDLE: assert property (!pop |=> !rdy_ff)
    else $error("ready without a data word");
  AST_ADDR_STEP: assert property (
    s_issue_step |=> start || ce_s ||
    fetch_addr_ff == bfsr_next_addr($past(fetch_addr_ff), burst_mode, wrap_en))
    else $error("burst address step wrong");
  AST_WRAP_GROUP: assert property (
    (active && wrap_en && !is_cont && !start) |->
    (fetch_addr_ff & ~grp_mask) == (base_ff & ~grp_mask))
    else $error("wrapped burst left its aligned group");

endmodule

// [tb/bfsr_host.sv]
// host controller model for the muxed pins of the burst read port
// assumes its tasks are called just after a falling edge of clk
`timescale 1ns/1ps

module bfsr_host (
  input wire logic clk,
  output logic ce_n,
  output logic address_valid_n,
  output logic oe_n,
  output logic [15:0] bus_in
);
  // ====
  // pin drive
  initial begin
    ce_n = 1'h1;
    address_valid_n = 1'h1;
    oe_n = 1'h1;
    bus_in = 16'hFFFF;
  end

  task automatic begin_read(input logic [15:0] a, input logic oe_low);
    ce_n = 1'h0;
    oe_n = !oe_low;
    address_valid_n = 1'h0;
    bus_in = a;
    @(negedge clk);
    address_valid_n = 1'h1;
    @(negedge clk);
    // released bus shows the inverse so a stale address never looks valid
    bus_in = ~a;
  endtask

  task automatic end_read();
    ce_n = 1'h1;
    oe_n = 1'h1;
    bus_in = ~bus_in;
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the burst read port with a host model
// assumes the array is loaded through the load port before any read
`timescale 1ns/1ps

module tb_top import bfsr_pkg::*;;
  logic clk;
  logic rst_n;
  logic [3:0] wait_states;
  bfsr_burst_t mode;
  logic wrap_en;
  logic mem_wr_en;
  logic [7:0] mem_wr_addr;
  logic [15:0] mem_wr_data;
  logic ce_n, addr_valid_n, oe_n;
  logic [15:0] bus_in, bus_out;
  logic bus_oe, rdy_out, rdy_oe;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  bfsr_host bfsr_host_i (.clk(clk), .ce_n(ce_n), .address_valid_n(addr_valid_n), .oe_n(oe_n),
    .bus_in(bus_in));
  bfsr_port #(.ADDR_W(8)) bfsr_port_i (.clk(clk), .rst_n(rst_n), .ce_n(ce_n),
    .address_valid_n(addr_valid_n), .oe_n(oe_n), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .rdy_out(rdy_out), .rdy_oe(rdy_oe), .wait_state_count(wait_states),
    .burst_mode(mode), .wrap_en(wrap_en), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

  // ====
  // clock, well above every burst minimum rate
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ====
  // helpers
  function automatic logic [15:0] word_of(input logic [15:0] a);
    return {~a[7:0], a[7:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ====
  // scenarios
  task automatic sc_burst(input logic [15:0] base, input bfsr_burst_t m, input logic wr,
      input logic [3:0] w);
    int len;
    int k;
    logic [15:0] a;
    logic [15:0] msk;
    len = (m == BM_LIN8) ? 8 : (m == BM_LIN16) ? 16 : (m == BM_LIN32) ? 32 : 40;
    msk = 16'(len - 1);
    mode = m;
    wrap_en = wr;
    wait_states = w;
    @(negedge clk);
    bfsr_host_i.begin_read(base, 1'h1);
    k = 2;
    while (rdy_out !== 1'h1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check(16'(k), 16'(w) + 16'h2);
    for (int i = 0; i < len; i++) begin
      a = (wr && m != BM_CONT) ? ((base & ~msk) | ((base + 16'(i)) & msk)) : base + 16'(i);
      check(bus_out, word_of(a));
      check(16'(rdy_out), 16'h1);
      check(16'(bus_oe), 16'h1);
      @(negedge clk);
    end
    if (m != BM_CONT) begin
      check(16'(rdy_out), 16'h0);
    end
    bfsr_host_i.end_read();
    repeat (4) @(negedge clk);
  endtask

  // abort in mid-wait with output enable high: bus floats throughout, ready floats once aborted, and no word follows
  task automatic sc_float();
    @(negedge clk);
    bfsr_host_i.begin_read(16'h0020, 1'h0);
    repeat (2) @(negedge clk);
    check(16'(bus_oe), 16'h0);
    check(16'(rdy_oe), 16'h1);
    bfsr_host_i.end_read();
    repeat (3) @(negedge clk);
    check(16'(rdy_oe), 16'h0);
    repeat (12) begin
      @(negedge clk);
      check(16'(rdy_out), 16'h0);
    end
  endtask

  // ====
  // main sequence
  initial begin
    rst_n = 1'h0;
    wait_states = 4'h8;
    mode = BM_LIN8;
    wrap_en = 1'h0;
    mem_wr_en = 1'h0;
    mem_wr_addr = 8'h00;
    mem_wr_data = 16'h0000;
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    repeat (20) @(negedge clk);
    for (int i = 0; i < 256; i++) begin
      mem_wr_en = 1'h1;
      mem_wr_addr = 8'(i);
      mem_wr_data = word_of(16'(i));
      @(negedge clk);
    end
    mem_wr_en = 1'h0;
    sc_burst(16'h0005, BM_LIN8, 1'h1, 4'h2);
    sc_burst(16'h0006, BM_LIN8, 1'h0, 4'h3);
    sc_burst(16'h001D, BM_LIN16, 1'h1, 4'h5);
    sc_burst(16'h0043, BM_LIN32, 1'h0, 4'h8);
    sc_burst(16'h0090, BM_CONT, 1'h0, 4'h6);
    sc_float();
    test_done();
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
endmodule
